// [design/digital_io_ports.sv]
// byte-wide i/o port bank on the host i/o bus plus relay expander with keep-alive
module digital_io_ports
#(
  parameter int unsigned KEEPALIVE_CYCLES = dio_pkg::KEEPALIVE_CYCLES // keep-alive timeout
)
(
  input  wire logic        mclk_in,            // 40 mhz clock
  input  wire logic        reset_n_in,         // synchronous reset, active low
  input  wire logic [15:0] io_addr_in,         // host i/o address
  input  wire logic        io_rd_in,           // read strobe, one cycle
  input  wire logic        io_wr_in,           // write strobe, one cycle
  input  wire logic [7:0]  io_wdata_in,        // write data
  output logic      [7:0]  io_rdata_out,       // read data, one cycle after strobe
  input  wire logic [11:0] ext_in_n_in,        // external inputs 1-12, active low
  input  wire logic [7:0]  internal_in_in,     // spare internal inputs
  output logic      [11:0] ext_out_n_out,      // external outputs 1-12, active low
  output logic      [7:0]  internal_out_out,   // spare internal outputs
  output logic      [7:0]  status_out,         // status lines, active low
  output logic      [7:0]  aux_status_out,     // spare auxiliary status lines
  input  wire logic        i2c_scl_in,         // relay i2c clock
  input  wire logic        i2c_sda_in,         // relay i2c data in
  output logic             i2c_sda_out,        // relay i2c data out, always low
  output logic             i2c_sda_oe_out,     // high while acking
  output logic      [7:0]  relay_port_out,     // relay expander bits, released when idle
  output logic             relay_active_out,   // relay board active
  output logic             zero_air_pump_n_out // zero-air pump, low runs it
);
  // refuse a timeout that the keep-alive counter cannot serve
  if (KEEPALIVE_CYCLES < 2)
  begin : g_bad_timeout
    $error("keep-alive timeout too short");
  end

  relay_if rif ();

  logic [11:0] ext_s1_reg;
  logic [11:0] ext_s2_reg;
  logic [7:0]  int_s1_reg;
  logic [7:0]  int_s2_reg;
  logic [7:0]  relay_reg;
  logic        keep_prev_reg;
  logic [31:0] alive_cnt_reg;

  // address decode and read mux
  wire sel_ext_lo = (io_addr_in == dio_pkg::EXT_LOW_ADDR);
  wire sel_int    = (io_addr_in == dio_pkg::INTERNAL_ADDR);
  wire sel_stat   = (io_addr_in == dio_pkg::STATUS_ADDR);
  wire sel_aux    = (io_addr_in == dio_pkg::AUX_STATUS_ADDR);
  wire sel_ext_hi = (io_addr_in == dio_pkg::EXT_HIGH_ADDR);
  wire [7:0] rd_ext_lo = {dio_pkg::INPUT_PAD_ONES, ext_s2_reg[5:0]};
  wire [7:0] rd_ext_hi = {dio_pkg::INPUT_PAD_ONES, ext_s2_reg[11:6]};
  wire [7:0] rd_next   = sel_ext_lo ? rd_ext_lo :
                         sel_ext_hi ? rd_ext_hi :
                         sel_int    ? int_s2_reg : dio_pkg::UNMAPPED_READ;
  wire keep_toggle = rif.byte_valid & rif.byte_first &
                     (rif.byte_data[dio_pkg::KEEPALIVE_BIT] != keep_prev_reg);
  wire alive_next  = keep_toggle | (relay_active_out &
                     (alive_cnt_reg < KEEPALIVE_CYCLES - 1));
  // relay byte as it will stand after this edge
  wire [7:0] relay_next = (rif.byte_valid & rif.byte_first) ? rif.byte_data : relay_reg;

  // pump follows the registered relay bit, sda is only ever pulled low
  assign zero_air_pump_n_out = relay_port_out[dio_pkg::PUMP_BIT];
  assign i2c_sda_out         = 1'b0;

  // input synchronisers
  always_ff @(posedge mclk_in)
  begin
    ext_s1_reg <= ext_in_n_in;
    ext_s2_reg <= ext_s1_reg;
    int_s1_reg <= internal_in_in;
    int_s2_reg <= int_s1_reg;
  end

  // registered read data
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      io_rdata_out <= dio_pkg::UNMAPPED_READ;
    else if (io_rd_in)
      io_rdata_out <= rd_next;
  end

  // output port latches
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      ext_out_n_out    <= {dio_pkg::PORT_RESET[3:0], dio_pkg::PORT_RESET};
      internal_out_out <= dio_pkg::PORT_RESET;
      status_out       <= dio_pkg::PORT_RESET;
      aux_status_out   <= dio_pkg::PORT_RESET;
    end
    else if (io_wr_in)
    begin
      if (sel_ext_lo)
        ext_out_n_out[7:0] <= io_wdata_in;
      if (sel_ext_hi)
        ext_out_n_out[11:8] <= io_wdata_in[3:0];
      if (sel_int)
        internal_out_out <= io_wdata_in;
      if (sel_stat)
        status_out <= io_wdata_in;
      if (sel_aux)
        aux_status_out <= io_wdata_in;
    end
  end

  // relay latch and keep-alive timer
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      relay_reg        <= dio_pkg::PORT_RESET;
      keep_prev_reg    <= 1'b1;
      alive_cnt_reg    <= 32'h0;
      relay_active_out <= 1'b0;
      relay_port_out   <= dio_pkg::PORT_RESET;
    end
    else
    begin
      if (rif.byte_valid && rif.byte_first)
      begin
        relay_reg     <= rif.byte_data;
        keep_prev_reg <= rif.byte_data[dio_pkg::KEEPALIVE_BIT];
      end
      relay_active_out <= alive_next;
      relay_port_out   <= alive_next ? relay_next : dio_pkg::PORT_RESET;
      alive_cnt_reg    <= keep_toggle ? 32'h0 : alive_cnt_reg + 32'h1;
    end
  end

  i2c_byte_receiver u_rx
  (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .scl_in     (i2c_scl_in),
    .sda_in     (i2c_sda_in),
    .sda_oe_out (i2c_sda_oe_out),
    .rx         (rif.rx)
  );

  // checks on port behaviour
  rd_low_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_rd_in && sel_ext_lo |=> io_rdata_out == {2'h3, $past(ext_s2_reg[5:0])})
    else $error("low input port read wrong");
  rd_high_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_rd_in && sel_ext_hi |=> io_rdata_out[7:6] == 2'h3 &&
    io_rdata_out[5:0] == $past(ext_s2_reg[11:6]))
    else $error("high input port read wrong");
  wr_low_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_wr_in && sel_ext_lo |=> ext_out_n_out[7:0] == $past(io_wdata_in))
    else $error("low output port not written");
  wr_high_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_wr_in && sel_ext_hi |=> ext_out_n_out[11:8] == $past(io_wdata_in[3:0]) &&
    $stable(ext_out_n_out[7:0]))
    else $error("high output port not written");
  rd_internal_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_rd_in && sel_int |=> io_rdata_out == $past(int_s2_reg))
    else $error("internal input read wrong");
  wr_internal_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_wr_in && sel_int |=> internal_out_out == $past(io_wdata_in) && $stable(status_out))
    else $error("internal output not written");
  wr_status_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_wr_in && sel_stat |=> status_out == $past(io_wdata_in) && $stable(aux_status_out))
    else $error("status port not written");
  wr_aux_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    io_wr_in && sel_aux |=> aux_status_out == $past(io_wdata_in))
    else $error("aux status port not written");
  relay_idle_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !relay_active_out |-> zero_air_pump_n_out && relay_port_out == 8'hff)
    else $error("relay outputs live while inactive");
  relay_timeout_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    relay_active_out && alive_cnt_reg >= KEEPALIVE_CYCLES - 1 && !keep_toggle
    |=> !relay_active_out)
    else $error("relay stayed active after timeout");
  pump_follow_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    relay_active_out |-> zero_air_pump_n_out == relay_reg[1])
    else $error("pump does not follow bit 1");
  reset_release_a: assert property (@(posedge mclk_in)
    !reset_n_in |=> ext_out_n_out == 12'hfff && status_out == 8'hff &&
    internal_out_out == 8'hff && aux_status_out == 8'hff && !relay_active_out)
    else $error("outputs not released after reset");
endmodule : digital_io_ports

// [design/i2c_byte_receiver.sv]
// write-only i2c slave that hands received data bytes to the relay latch
module i2c_byte_receiver
(
  input  wire logic mclk_in,    // system clock
  input  wire logic reset_n_in, // synchronous reset, active low
  input  wire logic scl_in,     // i2c clock pin
  input  wire logic sda_in,     // i2c data pin
  output logic      sda_oe_out, // high while pulling sda low for ack
  relay_if.rx       rx          // received bytes
);
  typedef enum logic [2:0] {IDLE, ADDR, DATA, ACK, SKIP} rx_state_t;

  rx_state_t  state_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic [7:0] shift_reg;
  logic [3:0] count_reg;
  logic       first_reg;

  // edges seen on the second synchroniser stage only
  wire scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
  wire scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
  wire start_c  = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  wire stop_c   = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
  wire byte_end = scl_fall & (count_reg == 4'h8);
  wire addr_hit = (shift_reg == dio_pkg::RELAY_I2C_ADDR);

  // pin synchronisers
  always_ff @(posedge mclk_in)
  begin
    scl_sync_reg <= {scl_sync_reg[0], scl_in};
    sda_sync_reg <= {sda_sync_reg[0], sda_in};
    scl_prev_reg <= scl_sync_reg[1];
    sda_prev_reg <= sda_sync_reg[1];
  end

  // byte framing, address match and ack
  always_ff @(posedge mclk_in)
  begin
    rx.byte_valid <= 1'b0;
    if (!reset_n_in || stop_c)
    begin
      state_reg  <= IDLE;
      sda_oe_out <= 1'b0;
      count_reg  <= 4'h0;
      first_reg  <= 1'b0;
    end
    else if (start_c)
    begin
      state_reg  <= ADDR;
      sda_oe_out <= 1'b0;
      count_reg  <= 4'h0;
    end
    else
    begin
      case (state_reg)
        ADDR, DATA:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
            count_reg <= count_reg + 4'h1;
          end
          else if (byte_end && state_reg == ADDR)
          begin
            state_reg  <= addr_hit ? ACK : SKIP;
            sda_oe_out <= addr_hit;
            first_reg  <= 1'b1;
          end
          else if (byte_end)
          begin
            rx.byte_valid <= 1'b1;
            rx.byte_first <= first_reg;
            rx.byte_data  <= shift_reg;
            first_reg     <= 1'b0;
            state_reg     <= ACK;
            sda_oe_out    <= 1'b1;
          end
        end
        ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_out <= 1'b0;
            count_reg  <= 4'h0;
            state_reg  <= DATA;
          end
        end
        SKIP:    state_reg <= SKIP;
        default: state_reg <= IDLE;
      endcase
    end
  end
endmodule : i2c_byte_receiver

// [shared/dio_pkg.sv]
// constants for the digital i/o port bank and relay expander
package dio_pkg;
  localparam int          IO_AW              = 16;
  localparam logic [15:0] EXT_LOW_ADDR       = 16'h0321;
  localparam logic [15:0] INTERNAL_ADDR      = 16'h0322;
  localparam logic [15:0] STATUS_ADDR        = 16'h0323;
  localparam logic [15:0] AUX_STATUS_ADDR    = 16'h0324;
  localparam logic [15:0] EXT_HIGH_ADDR      = 16'h0325;
  localparam logic [7:0]  PORT_RESET         = 8'hff;
  localparam logic [7:0]  UNMAPPED_READ      = 8'hff;
  localparam logic [1:0]  INPUT_PAD_ONES     = 2'h3;
  localparam int          IN_GROUP_W         = 6;
  localparam int          OUT_LOW_W          = 8;
  localparam int          OUT_HIGH_W         = 4;
  localparam int          HEALTHY_BIT        = 0;
  localparam int          SEQUENCE_BIT       = 2;
  localparam int          DIAG_BIT           = 3;
  localparam int          THERMAL_BIT        = 4;
  localparam int          PRESSURE_BIT       = 5;
  localparam logic [7:0]  RELAY_I2C_ADDR     = 8'h44;
  localparam int          KEEPALIVE_BIT      = 0;
  localparam int          PUMP_BIT           = 1;
  localparam int          KEEPALIVE_S        = 5;
  localparam int          CLK_HZ             = 40_000_000;
  localparam int          KEEPALIVE_CYCLES   = KEEPALIVE_S * CLK_HZ;
endpackage : dio_pkg

// [shared/relay_if.sv]
// byte stream from the i2c receiver to the relay latch
interface relay_if;
  logic       byte_valid; // one-cycle pulse per accepted data byte
  logic       byte_first; // byte is the first after the address
  logic [7:0] byte_data;  // received byte
  modport rx   (output byte_valid, output byte_first, output byte_data);
  modport sink (input byte_valid, input byte_first, input byte_data);
endinterface : relay_if

// [verif/relay_host_model.sv]
// host-side i2c master that writes the relay expander
module relay_host_model
(
  input  wire logic mclk_in,    // system clock
  input  wire logic sda_in,     // resolved sda line
  output logic      scl_out,    // i2c clock, parked high
  output logic      sda_low_out // high pulls sda low
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: clock high, data released
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // third of an scl period, keeps phases above the sync delay
  task automatic gap();
    repeat (4) @(posedge mclk_in);
  endtask : gap
  // start condition: sda falls while scl high
  task automatic start();
    sda_low_out <= 1'b1;
    gap();
    scl_out <= 1'b0;
    gap();
  endtask : start
  // one bit slot, data changes only while scl low
  task automatic clock_bit(input logic b, output logic seen);
    sda_low_out <= ~b;
    gap();
    scl_out <= 1'b1;
    gap();
    seen = sda_in;
    scl_out <= 1'b0;
    gap();
  endtask : clock_bit
  // byte msb first, then the ack slot with sda released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], seen);
    clock_bit(1'b1, seen);
    ack = ~seen;
  endtask : send_byte
  // stop condition: sda rises while scl high
  task automatic stop();
    sda_low_out <= 1'b1;
    gap();
    scl_out <= 1'b1;
    gap();
    sda_low_out <= 1'b0;
    gap();
  endtask : stop
endmodule : relay_host_model

// [verif/test_instrument_digital_io_ports.sv]
// self-checking bench for the i/o port bank and relay expander
module test_instrument_digital_io_ports;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned KA = 512; // shortened keep-alive timeout
  logic        mclk_in = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [11:0] ext_in_n = 12'hfff;
  logic [7:0]  int_in = 8'h00;
  logic [7:0]  rdata, int_out, status, aux, relay_port;
  logic [11:0] ext_out_n;
  logic        sda_out, sda_oe, relay_active, pump_n, scl, m_low, ack;
  wire         sda_line = ~(m_low | sda_oe); // pulled up when released
  int          seed = 88870;
  int          fails = 0;
  int          comparisons = 0;
  logic [7:0]  d [0:4];
  // 40 mhz clock
  always #12.5 mclk_in = ~mclk_in;
  digital_io_ports #(.KEEPALIVE_CYCLES(KA)) digital_io_ports_i
  (.mclk_in(mclk_in), .reset_n_in(reset_n), .io_addr_in(addr), .io_rd_in(rd), .io_wr_in(wr),
   .io_wdata_in(wdata), .io_rdata_out(rdata), .ext_in_n_in(ext_in_n), .internal_in_in(int_in),
   .ext_out_n_out(ext_out_n), .internal_out_out(int_out), .status_out(status),
   .aux_status_out(aux), .i2c_scl_in(scl), .i2c_sda_in(sda_line), .i2c_sda_out(sda_out),
   .i2c_sda_oe_out(sda_oe), .relay_port_out(relay_port), .relay_active_out(relay_active),
   .zero_air_pump_n_out(pump_n));
  relay_host_model relay_host_model_i
  (.mclk_in(mclk_in), .sda_in(sda_line), .scl_out(scl), .sda_low_out(m_low));
  // compare and count
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  // write strobe for one cycle, callable back to back
  task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_in);
  endtask : io_wr
  // drop the strobe and let its edge settle
  task automatic io_end();
    wr <= 1'b0;
    @(posedge mclk_in);
    #1;
  endtask : io_end
  // read strobe, data compared after the taking edge
  task automatic io_rd(input logic [15:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    chk_val(12'(rdata), 12'(exp));
    @(posedge mclk_in);
  endtask : io_rd
  // status byte from {press alarm, temp alarm, diag, sequence}
  function automatic logic [7:0] stat_val(input logic [3:0] f);
    return {2'b11, ~f[3], ~f[2], ~f[1], ~f[0], 1'b1, f[3] | f[2] | f[1]};
  endfunction : stat_val
  // one relay transaction, address ack checked
  task automatic relay_wr(input logic [7:0] a, input logic [7:0] v, input logic exp_ack);
    relay_host_model_i.start();
    relay_host_model_i.send_byte(a, ack);
    chk_val(12'(ack), 12'(exp_ack));
    if (ack)
    begin
      relay_host_model_i.send_byte(v, ack);
      chk_val(12'(ack), 12'h001);
    end
    relay_host_model_i.stop();
    repeat (4) @(posedge mclk_in);
    #1;
  endtask : relay_wr
  // all ports released, read data idle and relay inactive after a reset
  task automatic reset_chk();
    chk_val(ext_out_n, 12'hfff);
    chk_val({int_out, 4'hf}, 12'hfff);
    chk_val({status, 4'hf}, 12'hfff);
    chk_val({aux, 4'hf}, 12'hfff);
    chk_val({rdata, 4'hf}, 12'hfff);
    chk_val({2'h0, relay_active, sda_out, relay_port}, 12'h0ff);
  endtask : reset_chk
  // counts and verdict
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // watchdog against a hang
  initial
  begin
    repeat (6000) @(posedge mclk_in);
    fails++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge mclk_in);
    reset_n <= 1'b1;
    @(posedge mclk_in);
    #1;
    reset_chk();
    $display("test reset done");
    @(posedge mclk_in);
    repeat (6)
    begin
      for (int i = 0; i < 5; i++) d[i] = 8'($random(seed));
      io_wr(dio_pkg::EXT_LOW_ADDR, d[0]);
      io_wr(dio_pkg::EXT_HIGH_ADDR, d[1]);
      io_wr(dio_pkg::INTERNAL_ADDR, d[2]);
      io_wr(dio_pkg::AUX_STATUS_ADDR, d[3]);
      io_wr(16'h0330, d[4]); // unmapped, ignored
      io_end();
      chk_val(ext_out_n, {d[1][3:0], d[0]});
      chk_val(12'(int_out), 12'(d[2]));
      chk_val(12'(aux), 12'(d[3]));
      @(posedge mclk_in);
      ext_in_n <= 12'($random(seed));
      int_in <= 8'($random(seed));
      repeat (4) @(posedge mclk_in);
      io_rd(dio_pkg::EXT_LOW_ADDR, {2'b11, ext_in_n[5:0]});
      io_rd(dio_pkg::EXT_HIGH_ADDR, {2'b11, ext_in_n[11:6]});
      io_rd(dio_pkg::INTERNAL_ADDR, int_in);
      io_rd(16'h0320, dio_pkg::UNMAPPED_READ);
      io_rd(dio_pkg::AUX_STATUS_ADDR, dio_pkg::UNMAPPED_READ);
    end
    $display("test ports done");
    for (int f = 0; f < 16; f++)
    begin
      io_wr(dio_pkg::STATUS_ADDR, stat_val(4'(f)));
      io_end();
      chk_val(12'(status), 12'(stat_val(4'(f))));
      @(posedge mclk_in);
    end
    $display("test status done");
    // mid-run reset with ports holding written values
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk_in);
    reset_n <= 1'b1;
    @(posedge mclk_in);
    #1;
    reset_chk();
    $display("test mid-run reset done");
    relay_wr(8'h46, 8'h00, 1'b0);
    chk_val(12'(relay_active), 12'h000);
    relay_wr(dio_pkg::RELAY_I2C_ADDR, 8'hfc, 1'b1);
    chk_val({2'h0, relay_active, pump_n, relay_port}, 12'h2fc);
    relay_wr(dio_pkg::RELAY_I2C_ADDR, 8'hc3, 1'b1);
    chk_val({2'h0, relay_active, pump_n, relay_port}, 12'h3c3);
    repeat (KA + 8) @(posedge mclk_in);
    #1;
    chk_val({2'h0, relay_active, pump_n, relay_port}, 12'h1ff);
    $display("test relay done");
    complete_run();
  end
endmodule : test_instrument_digital_io_ports
